//--- logic/mia_pkg.sv
// Shared constants and types for the serial-line memory access block.
// Assumes one 100 MHz clock and a pulled-up, open-drain line.
package mia_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int  CLK_HZ    = 100_000_000;
  localparam real EE_WR_MS  = 6.5;
  localparam real EE_RD_US  = 2.0;
  localparam int  EE_WR_CYC = $rtoi(EE_WR_MS * CLK_HZ / 1.0e3);
  localparam int  EE_RD_CYC = $rtoi(EE_RD_US * CLK_HZ / 1.0e6);
  localparam int  EE_WR_W   = 20;
  localparam int  EE_RD_W   = 8;
  localparam int  CNT_W     = 16;
  localparam logic [CNT_W-1:0] SYNC_MAX = 16'h3fff;
  localparam logic [CNT_W-1:0] MIN_HALF = 16'h0004;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [4:0] RD_BITS    = 5'h0b;
  localparam logic [4:0] WR_BITS    = 5'h1b;
  localparam logic [4:0] SYNC_BITS  = 5'h02;
  localparam logic [4:0] CRC_BITS   = 5'h03;
  localparam logic [4:0] REPLY_BITS = 5'h15;
  localparam logic [4:0] DATA_END   = 5'h12;
  localparam logic [2:0] CRC_SEED   = 3'h7;

  // ****************************************
  // Primary registers and bits
  // ****************************************
  localparam logic [4:0] A_WR_TGT = 5'h01;
  localparam logic [4:0] A_WR_HI  = 5'h02;
  localparam logic [4:0] A_WR_LO  = 5'h03;
  localparam logic [4:0] A_WR_CTL = 5'h04;
  localparam logic [4:0] A_RD_TGT = 5'h05;
  localparam logic [4:0] A_RD_CTL = 5'h06;
  localparam logic [4:0] A_RD_HI  = 5'h07;
  localparam logic [4:0] A_RD_LO  = 5'h08;
  localparam logic [4:0] A_ERR    = 5'h0f;
  localparam logic [4:0] A_KEY    = 5'h1e;
  localparam int B_TRIG = 15;
  localparam int B_BUSY = 8;
  localparam int B_DONE = 0;
  localparam int B_XEE  = 14;
  localparam int B_CUST = 1;
  localparam logic [15:0] KEY_FIRST  = 16'hc418;
  localparam logic [15:0] KEY_SECOND = 16'h0e81;

  // ****************************************
  // Extended map
  // ****************************************
  localparam logic [7:0] EXT_SHADOW = 8'h40;
  localparam logic [7:0] EXT_VOL    = 8'h80;
  localparam logic [7:0] EXT_LAST   = 8'haa;
  localparam logic [7:0] EXT_COMM   = 8'ha6;
  localparam logic [7:0] EXT_LOCK   = 8'h24;
  localparam int         NV_WORDS   = 64;
  localparam int         VOL_WORDS  = 43;
  localparam int         COMM_BIT   = 15;
  localparam int         LOCK_HI    = 21;
  localparam int         LOCK_LO    = 18;
  localparam logic [3:0] LOCK_NV    = 4'hc;
  localparam logic [3:0] LOCK_ALL   = 4'h3;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_SYNC = 3'h2,
    RX_BITS = 3'h4
  } mia_rx_e;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_GAP  = 3'h2,
    TX_SEND = 3'h4
  } mia_tx_e;

  typedef struct packed {
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] data;
  } mia_frame_s;

endpackage : mia_pkg

//--- logic/mia_crc3.sv
// Serial 3-bit frame check, one covered bit per step.
// Assumes the caller clears it before the first covered bit.
module mia_crc3 import mia_pkg::*; (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clear,
  input  wire logic       step,
  input  wire logic       din,
  output logic      [2:0] crc
);

  logic [2:0] crc_d;

  // One assignment for the whole word: bit 1 builds on the new bit 0
  assign crc_d = {crc[1], crc[2] ^ din ^ crc[0], crc[2] ^ din};

  always_ff @(posedge clk) begin
    if (reset || clear) begin
      crc <= CRC_SEED;
    end else if (step) begin
      crc <= crc_d;
    end
  end

  AST_CRC_SEED: assert property (@(posedge clk) disable iff (reset)
    clear |=> crc == CRC_SEED)
    else $error("check not seeded");

  AST_CRC_STEP: assert property (@(posedge clk) disable iff (reset)
    step && !clear |=> crc[2] == $past(crc[1])
      && crc[0] == ($past(crc[2]) ^ $past(din))
      && crc[1] == (crc[0] ^ $past(crc[0])))
    else $error("check update wrong");

endmodule : mia_crc3

//--- logic/mia_core.sv
// Manchester frame receiver/replier, primary registers and the
// indirect engine for nonvolatile, shadow and volatile memory.
// Assumes line_in is synchronous and the line idles high.

// Functional notes
// - Read request: sync, rw, address, check
// - Valid read answered with data and check
// - Write frame: sync, rw, address, data, check
// - Frame address selects primary register written
// - Check seeded ones, skips sync bits
// - Check register update per covered bit
// - Copy nonvolatile to shadow after reset, write
// - Shadow sits 0x40 above nonvolatile copy
// - Extended writes need unlock; reads never
// - Comm enable cleared by write or reset
// - Key port bit shows unlock; primaries free
// - Lock 0xC blocks only nonvolatile writes
// - Lock 0x3 blocks all extended writes
// - Programmed lock field cannot be changed
// - Write trigger stores word; reads zero
// - Busy during write, done when finished
// - Failed extended write raises error flag
// - Read trigger fetches word into registers
// - Read done set when fetch completes
// - Falling mid-bit is one, MSB first
// - Two zero sync bits, then rw bit
// - Follow host rate, reply at same
module mia_core import mia_pkg::*; #(
  parameter int EE_WR_CYCLES = EE_WR_CYC
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic line_in,
  output logic      line_out,
  output logic      line_oe,
  input  wire logic aux_enter,
  output logic      line_comm_enable
);

  // ****************************************
  // State
  // ****************************************
  // Blank at power-up only; no reset clears it
  logic [31:0]        nv_mem     [0:NV_WORDS-1] = '{default: '0};
  logic [31:0]        shadow_mem [0:NV_WORDS-1];
  logic [31:0]        vol_mem    [0:VOL_WORDS-1];
  mia_rx_e            rx_st_q;
  mia_tx_e            tx_st_q;
  logic               line_prev_q, rw_q, oe_q;
  logic [CNT_W-1:0]   rx_cnt_q, half_q, idle_q, tx_cnt_q;
  logic [4:0]         rx_n_q, tx_n_q;
  logic [24:0]        rx_sh_q;
  logic [20:0]        tx_sh_q;
  logic [7:0]         wr_tgt_q, rd_tgt_q, rd_addr_q, ee_addr_q;
  logic [31:0]        wr_word_q, rd_word_q, ee_word_q;
  logic               wr_busy_q, wr_done_q, rd_busy_q, rd_done_q;
  logic               xee_q, key1_q, unlocked_q, comm_en_q;
  logic               copy_busy_q;
  logic [5:0]         copy_idx_q;
  logic [EE_WR_W-1:0] wr_cnt_q;
  logic [EE_RD_W-1:0] rd_cnt_q;

  // ****************************************
  // Decoders
  // ****************************************
  function automatic logic [15:0] stat_word(input logic busy,
                                            input logic done);
    stat_word = 16'h0000;
    stat_word[B_BUSY] = busy;
    stat_word[B_DONE] = done;
  endfunction : stat_word

  // Low six bits index every region: 0x40 and 0x80 are aligned
  function automatic logic [31:0] ext_rd(input logic [7:0] a);
    ext_rd = 32'h0000_0000;
    if (a < EXT_SHADOW) begin
      ext_rd = nv_mem[a[5:0]];
    end else if (a < EXT_VOL) begin
      ext_rd = shadow_mem[a[5:0]];
    end else if (a <= EXT_LAST) begin
      ext_rd = vol_mem[a[5:0]];
      if (a == EXT_COMM) begin
        ext_rd[COMM_BIT] = comm_en_q;
      end
    end
  endfunction : ext_rd

  function automatic logic [15:0] prim_rd(input logic [4:0] a);
    prim_rd = 16'h0000;
    case (a)
      A_WR_TGT: prim_rd = {8'h00, wr_tgt_q};
      A_WR_HI:  prim_rd = wr_word_q[31:16];
      A_WR_LO:  prim_rd = wr_word_q[15:0];
      A_WR_CTL: prim_rd = stat_word(wr_busy_q | copy_busy_q,
                                    wr_done_q);
      A_RD_TGT: prim_rd = {8'h00, rd_tgt_q};
      A_RD_CTL: prim_rd = stat_word(rd_busy_q, rd_done_q);
      A_RD_HI:  prim_rd = rd_word_q[31:16];
      A_RD_LO:  prim_rd = rd_word_q[15:0];
      A_ERR:    prim_rd[B_XEE] = xee_q;
      A_KEY:    prim_rd[B_CUST] = unlocked_q;
      default:  prim_rd = 16'h0000;
    endcase
  endfunction : prim_rd

  // ****************************************
  // Receiver
  // ****************************************
  logic [CNT_W-1:0] two_h, samp_pt, idle_max;
  logic             edge_w, fall_w, rise_w, rx_bit, sample_w, last_w;
  logic             crc_step, crc_ok, frm_ok;
  logic [2:0]       rx_crc;
  logic [24:0]      rx_word;
  mia_frame_s       frm;

  assign two_h    = {half_q[14:0], 1'b0};
  assign samp_pt  = half_q + {1'b0, half_q[15:1]};
  assign idle_max = {half_q[13:0], 2'b00};
  assign edge_w   = line_in ^ line_prev_q;
  assign fall_w   = line_prev_q & ~line_in;
  assign rise_w   = ~line_prev_q & line_in;
  assign rx_bit   = ~line_in;        // Late half low means one
  assign sample_w = (rx_st_q == RX_BITS) && (rx_cnt_q == samp_pt);
  assign last_w   = sample_w && ((rw_q && rx_n_q == RD_BITS - 5'h01)
                    || rx_n_q == WR_BITS - 5'h01);
  assign rx_word  = {rx_sh_q[23:0], rx_bit};
  assign crc_step = sample_w && rx_n_q >= SYNC_BITS
                    && rx_n_q < ((rw_q ? RD_BITS : WR_BITS) - CRC_BITS);
  assign crc_ok   = rx_word[2:0] == rx_crc;
  assign frm      = {~rw_q,
                     rw_q ? rx_word[7:3] : rx_word[23:19],
                     rx_word[18:3]};
  assign frm_ok   = last_w && crc_ok && comm_en_q;

  mia_crc3 u_rx_crc (
    .clk   (clk),
    .reset (reset),
    .clear (rx_st_q == RX_IDLE),
    .step  (crc_step),
    .din   (rx_bit),
    .crc   (rx_crc)
  );

  // Own transmissions are not heard: a new frame waits for tx idle
  always_ff @(posedge clk) begin
    line_prev_q <= reset ? 1'b1 : line_in;
    if (reset) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      half_q <= MIN_HALF;
      idle_q <= '0;
      rx_n_q <= '0;
      rx_sh_q <= '0;
      rw_q <= 1'b0;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          rx_cnt_q <= '0;
          rw_q <= 1'b0;
          if (fall_w && tx_st_q == TX_IDLE) begin
            rx_st_q <= RX_SYNC;
          end
        end
        RX_SYNC: begin
          rx_cnt_q <= rx_cnt_q + 16'h0001;
          if (rise_w && rx_cnt_q >= MIN_HALF) begin
            // Counter lags the line by one cycle in this state
            half_q <= rx_cnt_q + 16'h0001;
            idle_q <= '0;
            rx_n_q <= '0;
            rx_st_q <= RX_BITS;
          end else if (rise_w || rx_cnt_q == SYNC_MAX) begin
            rx_st_q <= RX_IDLE;
          end
        end
        RX_BITS: begin
          idle_q <= edge_w ? '0 : idle_q + 16'h0001;
          if (edge_w && rx_cnt_q > {1'b0, half_q[15:1]}
              && rx_cnt_q < samp_pt) begin
            rx_cnt_q <= half_q;                  // Mid-bit resync
          end else if (rx_cnt_q >= two_h - 16'h0001) begin
            rx_cnt_q <= '0;
          end else begin
            rx_cnt_q <= rx_cnt_q + 16'h0001;
          end
          if (sample_w) begin
            rx_n_q <= rx_n_q + 5'h01;
            rx_sh_q <= rx_word;                  // MSB first
            if (rx_n_q == SYNC_BITS) begin
              rw_q <= rx_bit;
            end
          end
          if (last_w || idle_q == idle_max) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ****************************************
  // Reply transmitter
  // ****************************************
  logic [2:0] tx_crc;
  logic       tx_lvl, tx_wrap, tx_load;

  assign tx_load  = frm_ok && !frm.wr;
  assign tx_wrap  = tx_cnt_q >= two_h - 16'h0001;
  assign tx_lvl   = (tx_cnt_q < half_q) ? tx_sh_q[20] : ~tx_sh_q[20];
  assign line_out = 1'b0;
  assign line_oe  = oe_q;

  mia_crc3 u_tx_crc (
    .clk   (clk),
    .reset (reset),
    .clear (tx_load),
    .step  (tx_st_q == TX_SEND && tx_cnt_q == '0
            && tx_n_q >= SYNC_BITS && tx_n_q < DATA_END),
    .din   (tx_sh_q[20]),
    .crc   (tx_crc)
  );

  always_ff @(posedge clk) begin
    oe_q <= !reset && tx_st_q == TX_SEND && !tx_lvl;
    if (reset) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_n_q <= '0;
      tx_sh_q <= '0;
    end else begin
      tx_cnt_q <= (tx_wrap || tx_st_q == TX_IDLE) ? '0
                  : tx_cnt_q + 16'h0001;         // Request rate
      case (tx_st_q)
        TX_IDLE: begin
          tx_n_q <= '0;
          if (tx_load) begin
            tx_sh_q <= {2'b00, prim_rd(frm.addr), 3'b000};
            tx_st_q <= TX_GAP;
          end
        end
        TX_GAP: begin
          if (tx_wrap) begin
            tx_st_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_wrap) begin
            tx_n_q <= tx_n_q + 5'h01;
            tx_sh_q <= (tx_n_q == DATA_END - 5'h01)
                       ? {tx_crc, 18'h00000}
                       : {tx_sh_q[19:0], 1'b0};
            if (tx_n_q == REPLY_BITS - 5'h01) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // Primary writes, unlock, indirect engine
  // ****************************************
  logic       pw, wr_trig, rd_trig, ew_go, er_go, ew_deny;
  logic       t_ee, t_sh, t_vol, r_ee, lock_nv, lock_all, ee_end;
  logic [3:0] lock;

  assign pw       = frm_ok && frm.wr;
  assign wr_trig  = pw && frm.addr == A_WR_CTL && frm.data[B_TRIG];
  assign rd_trig  = pw && frm.addr == A_RD_CTL && frm.data[B_TRIG];
  assign ew_go    = wr_trig && !wr_busy_q && !copy_busy_q;
  assign er_go    = rd_trig && !rd_busy_q;
  assign t_ee     = wr_tgt_q < EXT_SHADOW;
  assign t_sh     = !t_ee && wr_tgt_q < EXT_VOL;
  assign t_vol    = wr_tgt_q >= EXT_VOL && wr_tgt_q <= EXT_LAST;
  assign r_ee     = rd_tgt_q < EXT_SHADOW;
  assign lock     = nv_mem[EXT_LOCK[5:0]][LOCK_HI:LOCK_LO];
  assign lock_all = lock == LOCK_ALL;
  assign lock_nv  = lock == LOCK_NV || lock_all;
  assign ew_deny  = !unlocked_q
                    || (t_ee && lock_nv)
                    || ((t_sh || t_vol) && lock_all)
                    || !(t_ee || t_sh || t_vol);
  assign ee_end   = wr_busy_q && !copy_busy_q
                    && wr_cnt_q == EE_WR_W'(EE_WR_CYCLES - 1);
  assign line_comm_enable = comm_en_q;

  // Memories carry no reset: nonvolatile content must survive it
  always_ff @(posedge clk) begin
    if (ee_end) begin
      nv_mem[ee_addr_q[5:0]] <= ee_word_q;
    end
    if (copy_busy_q) begin
      shadow_mem[copy_idx_q] <= nv_mem[copy_idx_q];
    end else if (ew_go && !ew_deny && t_sh) begin
      shadow_mem[wr_tgt_q[5:0]] <= wr_word_q;
    end
    if (ew_go && !ew_deny && t_vol) begin
      vol_mem[wr_tgt_q[5:0]] <= wr_word_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      {wr_tgt_q, rd_tgt_q, rd_addr_q, ee_addr_q} <= '0;
      {wr_word_q, rd_word_q, ee_word_q} <= '0;
      {wr_busy_q, wr_done_q, rd_busy_q, rd_done_q} <= '0;
      {xee_q, key1_q, unlocked_q, comm_en_q} <= '0;
      copy_busy_q <= 1'b1;
      copy_idx_q <= '0;
      wr_cnt_q <= '0;
      rd_cnt_q <= '0;
    end else begin
      if (pw && frm.addr == A_WR_TGT) wr_tgt_q <= frm.data[7:0];
      if (pw && frm.addr == A_WR_HI)  wr_word_q[31:16] <= frm.data;
      if (pw && frm.addr == A_WR_LO)  wr_word_q[15:0] <= frm.data;
      if (pw && frm.addr == A_RD_TGT) rd_tgt_q <= frm.data[7:0];
      if (frm_ok) begin
        key1_q <= pw && frm.addr == A_KEY && frm.data == KEY_FIRST;
      end
      if (pw && key1_q && frm.addr == A_KEY
          && frm.data == KEY_SECOND) begin
        unlocked_q <= 1'b1;
      end
      if (aux_enter) begin
        comm_en_q <= 1'b1;
      end else if (ew_go && !ew_deny && wr_tgt_q == EXT_COMM) begin
        comm_en_q <= wr_word_q[COMM_BIT];
      end
      // Error flag clears on its read, but a new failure wins
      if (ew_go && ew_deny) begin
        xee_q <= 1'b1;
      end else if (frm_ok && !frm.wr && frm.addr == A_ERR) begin
        xee_q <= 1'b0;
      end
      if (ew_go) begin
        wr_done_q <= ew_deny || !t_ee;
        wr_busy_q <= !ew_deny && t_ee;
        wr_cnt_q <= '0;
        ee_addr_q <= wr_tgt_q;
        ee_word_q <= wr_word_q;
      end else if (wr_busy_q && !copy_busy_q) begin
        wr_cnt_q <= wr_cnt_q + EE_WR_W'(1);
        copy_busy_q <= ee_end;
        copy_idx_q <= '0;
      end else if (copy_busy_q) begin
        copy_idx_q <= copy_idx_q + 6'h01;
        if (copy_idx_q == 6'(NV_WORDS - 1)) begin
          copy_busy_q <= 1'b0;
          wr_done_q <= wr_done_q | wr_busy_q;
          wr_busy_q <= 1'b0;
        end
      end
      if (er_go) begin
        rd_done_q <= 1'b0;
        rd_busy_q <= 1'b1;
        rd_addr_q <= rd_tgt_q;
        rd_cnt_q <= r_ee ? EE_RD_W'(EE_RD_CYC - 1) : '0;
      end else if (rd_busy_q && rd_cnt_q != '0) begin
        rd_cnt_q <= rd_cnt_q - EE_RD_W'(1);
      end else if (rd_busy_q) begin
        rd_word_q <= ext_rd(rd_addr_q);
        rd_busy_q <= 1'b0;
        rd_done_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [15:0] wr_ctl_rd, key_rd;

  always_comb begin
    wr_ctl_rd = prim_rd(A_WR_CTL);
    key_rd    = prim_rd(A_KEY);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_BAD_CHECK: assert property (
    last_w && !crc_ok |=> tx_st_q == TX_IDLE && $stable(wr_word_q))
    else $error("bad frame acted upon");
  AST_STORE_HIGH: assert property (
    pw && frm.addr == A_WR_HI |=> wr_word_q[31:16] == $past(frm.data))
    else $error("write data not stored");
  AST_UNLOCK: assert property (
    pw && key1_q && frm.addr == A_KEY && frm.data == KEY_SECOND
    |=> unlocked_q && key_rd[B_CUST])
    else $error("unlock not shown");
  AST_DENY: assert property (
    ew_go && !unlocked_q |=> xee_q && wr_done_q && !wr_busy_q)
    else $error("locked write not refused");
  AST_NV_LOCK: assert property (
    ew_go && t_ee && lock == LOCK_NV |=> xee_q && !wr_busy_q)
    else $error("nonvolatile lock ignored");
  AST_ALL_LOCK: assert property (
    ew_go && t_sh && lock_all |=> xee_q)
    else $error("full lock ignored");
  AST_EE_BUSY: assert property (
    ew_go && t_ee && !ew_deny
    |=> wr_ctl_rd[B_BUSY] && !wr_done_q)
    else $error("busy not shown");
  AST_SHADOW_RD: assert property (
    er_go && !r_ee |=> rd_busy_q ##1 rd_done_q && !rd_busy_q)
    else $error("shadow fetch too slow");
  AST_RD_IGNORE: assert property (
    rd_busy_q && rd_trig |=> $stable(rd_addr_q))
    else $error("busy read retriggered");
  AST_COMM_OFF: assert property (
    ew_go && !ew_deny && !aux_enter && wr_tgt_q == EXT_COMM
    && !wr_word_q[COMM_BIT] |=> !line_comm_enable)
    else $error("comm mode not left");

endmodule : mia_core

//--- testbench/mia_host.sv
// Host controller model: sends frames on the open-drain line, reads replies.
// Assumes the bench forms the wire level from both pull-downs and a pull-up.
module mia_host import mia_pkg::*; (
  input  wire logic clk,
  input  wire logic line,
  output logic      host_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Framing
  // ****************
  int half = 12;

  initial host_low = 1'b0;

  function automatic logic [2:0] crc3(input logic [21:0] v, input int n);
    logic [2:0] c;
    logic       b;
    c = CRC_SEED;
    for (int i = 21; i > 21 - n; i--) begin
      b = c[2] ^ v[i];
      c = {c[1], b ^ c[0], b};
    end
    return c;
  endfunction : crc3

  // Level equals the bit in the first half, so a one falls mid-bit
  task automatic put(input logic b);
    host_low = ~b;
    repeat (half) @(negedge clk);
    host_low = b;
    repeat (half) @(negedge clk);
  endtask : put

  task automatic xfer(input logic rw, input logic [4:0] a,
                      input logic [15:0] d, input logic bad,
                      output logic got, output logic [15:0] q,
                      output logic ok);
    logic [21:0] v;
    logic [20:0] r;
    logic [2:0]  c;
    int          n;
    v = {rw, a, d};
    n = rw ? 6 : 22;
    c = crc3(v, n) ^ {2'h0, bad};
    put(1'b0);
    put(1'b0);
    for (int i = 21; i > 21 - n; i--) put(v[i]);
    for (int i = 2; i >= 0; i--) put(c[i]);
    host_low = 1'b0;
    got = 1'b0;
    ok = 1'b0;
    q = 16'h0;
    // A window with no falling edge means the device stayed silent
    for (int t = 0; rw && t < 8 * half && !got; t++) begin
      @(negedge clk);
      got = ~line;
    end
    if (got) begin
      repeat (half / 2) @(negedge clk);
      for (int i = 20; i >= 0; i--) begin
        r[i] = line;
        repeat (2 * half) @(negedge clk);
      end
      q = r[18:3];
      ok = (r[20:19] === 2'b00) && (r[2:0] === crc3({q, 6'h0}, 16));
    end
    repeat (4 * half) @(negedge clk);
  endtask : xfer

endmodule : mia_host

//--- testbench/mia_core_bench.sv
// Self-checking bench for the serial-line memory access core.
// Assumes a host model on the line; the core pulls the wire low only.
module mia_core_bench import mia_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Harness
  // ****************
  logic        clk;
  logic        reset;
  logic        aux_enter;
  logic        got;
  logic        ok;
  logic [15:0] q;
  wire         line_oe;
  wire         line_out_w;
  wire         comm;
  wire         host_low;
  wire         line = ~(line_oe | host_low);
  int          bad_count = 0;
  int          check_count = 0;

  mia_core #(.EE_WR_CYCLES(2000)) DUT (
    .clk(clk), .reset(reset), .line_in(line), .line_out(line_out_w),
    .line_oe(line_oe), .aux_enter(aux_enter), .line_comm_enable(comm));
  mia_host host (.clk(clk), .line(line), .host_low(host_low));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    check_count++;
    if (act !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    host.xfer(1'b0, a, d, 1'b0, got, q, ok);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    host.xfer(1'b1, a, 16'h0, 1'b0, got, q, ok);
    chk({15'h0, got & ok}, 16'h1);
    chk(q, exp);
  endtask : rd

  // Slow operations are polled; a poll that never matches ends the run
  task automatic poll(input logic [4:0] a, input logic [15:0] exp);
    for (int i = 0; i < 40; i++) begin
      host.xfer(1'b1, a, 16'h0, 1'b0, got, q, ok);
      if (got === 1'b1 && ok === 1'b1 && q === exp) return;
    end
    bad_count++;
    $display("Error at %0t: poll of %h timed out", $time, a);
    final_report();
  endtask : poll

  task automatic ext_wr(input logic [7:0] t, input logic [31:0] w);
    wr(A_WR_TGT, {8'h0, t});
    wr(A_WR_HI, w[31:16]);
    wr(A_WR_LO, w[15:0]);
    wr(A_WR_CTL, 16'h8000);
  endtask : ext_wr

  task automatic ext_rd(input logic [7:0] t, input logic [31:0] w);
    wr(A_RD_TGT, {8'h0, t});
    wr(A_RD_CTL, 16'h8000);
    poll(A_RD_CTL, 16'h0001);
    rd(A_RD_HI, w[31:16]);
    rd(A_RD_LO, w[15:0]);
  endtask : ext_rd

  // ****************
  // Sequence
  // ****************
  initial begin
    reset = 1'b1;
    aux_enter = 1'b0;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (80) @(negedge clk);
    host.xfer(1'b1, A_KEY, 16'h0, 1'b0, got, q, ok);
    chk({15'h0, got}, 16'h0);
    aux_enter = 1'b1;
    @(negedge clk);
    aux_enter = 1'b0;
    @(negedge clk);
    chk({15'h0, comm}, 16'h1);
    $display("test comm_entry done");
    wr(A_WR_TGT, 16'hffa5);
    rd(A_WR_TGT, 16'h00a5);
    host.half = 20;
    rd(A_WR_TGT, 16'h00a5);
    host.half = 12;
    wr(A_WR_HI, 16'h1111);
    host.xfer(1'b0, A_WR_HI, 16'h2222, 1'b1, got, q, ok);
    rd(A_WR_HI, 16'h1111);
    host.xfer(1'b1, A_WR_HI, 16'h0, 1'b1, got, q, ok);
    chk({15'h0, got}, 16'h0);
    $display("test primary done");
    ext_wr(8'h45, 32'h12345678);
    rd(A_WR_CTL, 16'h0001);
    rd(A_ERR, 16'h4000);
    rd(A_ERR, 16'h0000);
    ext_rd(8'h45, 32'h0);
    rd(A_KEY, 16'h0000);
    wr(A_KEY, KEY_FIRST);
    wr(A_KEY, KEY_SECOND);
    rd(A_KEY, 16'h0002);
    $display("test unlock done");
    ext_wr(8'h45, 32'h12345678);
    rd(A_WR_CTL, 16'h0001);
    ext_rd(8'h45, 32'h12345678);
    ext_wr(8'h05, 32'hcafe0001);
    wr(A_WR_CTL, 16'h8000);
    rd(A_WR_CTL, 16'h0100);
    poll(A_WR_CTL, 16'h0001);
    rd(A_ERR, 16'h0000);
    ext_rd(8'h45, 32'hcafe0001);
    ext_rd(8'h05, 32'hcafe0001);
    $display("test eeprom done");
    ext_wr(EXT_LOCK, 32'h00300000);
    poll(A_WR_CTL, 16'h0001);
    ext_wr(EXT_LOCK, 32'h000c0000);
    poll(A_WR_CTL, 16'h0001);
    rd(A_ERR, 16'h4000);
    ext_rd(EXT_LOCK, 32'h00300000);
    ext_wr(8'h46, 32'h0000beef);
    rd(A_ERR, 16'h0000);
    ext_rd(8'h46, 32'h0000beef);
    $display("test lock done");
    ext_wr(EXT_COMM, 32'h0);
    chk({15'h0, comm}, 16'h0);
    chk({15'h0, line_out_w}, 16'h0);
    $display("test comm_exit done");
    final_report();
  end

endmodule : mia_core_bench
